//--- hw/lsc_exec.sv
// Execution unit for loads, stores, counters, transfers and branches.
// Assumes an external decoder hands one operation with its effective
// address (or immediate byte) and a synchronous memory with one cycle
// read latency on the same clock.
//
// Function
// - Memory loads only read; no write strobe during a load.
// - Accumulator holds loaded byte until another operation writes it.
// - Accumulator load takes immediate operand byte instead of memory.
// - X and Y loads take immediate byte or memory byte likewise.
// - Stores write current A, X or Y byte to the address.
// - Stores leave the source register unchanged.
// - Stores have no immediate form; immediate store is refused.
// - Increment memory reads, adds one, writes back same address.
// - Index increment wraps 255 to 0.
// - Increment Y behaves as increment X, implied, no operand.
// - Increment memory works on any full 16-bit address.
// - Memory byte 255 increments to 0 with no carry out.
// - Decrements mirror increments, subtracting one modulo 256.
// - Copy X to accumulator leaves X unchanged.
// - Branch on nonzero falls through when zero flag set.
// - X and stack pointer copy both ways, source unchanged.
// - Instructions clear and set the interrupt mask bit.
`timescale 1ns/1ps
module lsc_exec
   import lsc_pkg::*;
#(
   parameter int unsigned ADDR_W = 16
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Instruction stream
   input  wire logic              op_valid,
   input  wire logic [4:0]        op_code,
   input  wire logic              op_immediate,
   input  wire logic [7:0]        op_operand,
   input  wire logic [ADDR_W-1:0] op_addr,
   input  wire logic [15:0]       op_next_pc,
   output logic                   op_ready,
   output logic                   op_done,
   output logic                   op_refused,
   // Memory bus
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rdata,
   // Architectural state
   output logic [7:0]             reg_acc,
   output logic [7:0]             reg_x,
   output logic [7:0]             reg_y,
   output logic [7:0]             reg_sp,
   output logic                   flag_zero,
   output logic                   flag_negative,
   output logic                   irq_mask,
   output logic [15:0]            pc
);

   if (ADDR_W != 16) begin : g_addr_check
      $error("lsc_exec needs a 16-bit address space");
   end

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic logic [7:0] step(input logic [7:0] v,
                                       input logic       up);
      // Eight-bit result: carry or borrow is dropped on purpose
      step = up ? 8'(v + 8'h01) : 8'(v - 8'h01);
   endfunction

   lsc_op_t     op;
   lsc_state_t  state;
   lsc_state_t  next_state;
   lsc_op_t     cur_op;
   logic [7:0]  mem_byte;

   assign op = lsc_op_t'(op_code);

   wire is_load  = op == OP_LOAD_ACCUMULATOR || op == OP_LOAD_INDEX_X
                || op == OP_LOAD_INDEX_Y;
   wire is_store = op == OP_STORE_ACCUMULATOR || op == OP_STORE_INDEX_X
                || op == OP_STORE_INDEX_Y;
   wire is_rmw   = op == OP_INCREMENT_MEMORY || op == OP_DECREMENT_MEMORY;
   wire cur_up   = cur_op == OP_INCREMENT_MEMORY;
   wire cur_rmw  = cur_op == OP_INCREMENT_MEMORY
                || cur_op == OP_DECREMENT_MEMORY;
   wire idle     = state == ST_IDLE;
   wire take     = idle && op_valid;
   wire refuse   = take && is_store && op_immediate;
   wire needs_rd = take && ((is_load && !op_immediate) || is_rmw);
   wire do_store = take && is_store && !op_immediate;
   wire [7:0] store_src = op == OP_STORE_INDEX_X ? reg_x :
                          op == OP_STORE_INDEX_Y ? reg_y : reg_acc;
   wire [7:0] rmw_result = step(mem_byte, cur_up);

   assign op_ready   = idle;
   assign op_refused = refuse;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (needs_rd) begin
               next_state = ST_READ;
            end else if (do_store) begin
               next_state = ST_WRITE;
            end
         end
         ST_READ:  next_state = ST_WAIT;
         ST_WAIT:  next_state = cur_rmw ? ST_WRITE : ST_DONE;
         ST_WRITE: next_state = ST_DONE;
         ST_DONE:  next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Memory port
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_op    <= OP_NOP;
         mem_addr  <= '0;
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
         mem_byte  <= 8'h00;
      end else begin
         mem_rd <= needs_rd;
         // write only for stores and counters
         mem_wr <= do_store || (state == ST_WAIT && cur_rmw);
         if (take) begin
            cur_op <= op;
            mem_addr <= op_addr;
         end
         if (do_store) begin
            mem_wdata <= store_src;
         end
         if (state == ST_WAIT) begin
            mem_byte <= mem_rdata;
         end
         // modified byte back to same address
         if (state == ST_WAIT && cur_rmw) begin
            mem_wdata <= step(mem_rdata, cur_up);
         end
      end
   end

   // ****************************************************************
   // Registers and flags
   // ****************************************************************
   logic [7:0] res;
   logic       upd_flags;
   always_comb begin
      res       = 8'h00;
      upd_flags = 1'b0;
      if (state == ST_WAIT && !cur_rmw) begin
         res       = mem_rdata;
         upd_flags = 1'b1;
      end else if (state == ST_DONE && cur_rmw) begin
         res       = rmw_result;
         upd_flags = 1'b1;
      end else if (take && !refuse) begin
         upd_flags = 1'b1;
         case (op)
            OP_LOAD_ACCUMULATOR, OP_LOAD_INDEX_X, OP_LOAD_INDEX_Y: begin
               res       = op_operand;
               upd_flags = op_immediate;
            end
            OP_INCREMENT_INDEX_X:       res = step(reg_x, 1'b1);
            OP_INCREMENT_INDEX_Y:       res = step(reg_y, 1'b1);
            OP_DECREMENT_INDEX_X:       res = step(reg_x, 1'b0);
            OP_DECREMENT_INDEX_Y:       res = step(reg_y, 1'b0);
            OP_COPY_X_TO_ACCUMULATOR:   res = reg_x;
            OP_COPY_STACK_POINTER_TO_X: res = reg_sp;
            default:                    upd_flags = 1'b0;
         endcase
      end
   end

   // Immediate loads finish at take; memory loads at the wait state
   wire [4:0] wr_op = (take && !refuse) ? op_code : cur_op;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_acc       <= RST_ACC;
         reg_x         <= RST_X;
         reg_y         <= RST_Y;
         reg_sp        <= RST_SP;
         irq_mask      <= RST_IRQ_MASK;
         flag_zero     <= 1'b0;
         flag_negative <= 1'b0;
         pc            <= RST_PC;
         op_done       <= 1'b0;
      end else begin
         op_done <= (take && !refuse && !needs_rd && !do_store)
                 || state == ST_DONE;
         // A, X and Y written only here, on result
         if (upd_flags) begin
            flag_zero     <= res == 8'h00;
            flag_negative <= res[7];
            case (lsc_op_t'(wr_op))
               OP_LOAD_ACCUMULATOR, OP_COPY_X_TO_ACCUMULATOR:
                  reg_acc <= res;
               OP_LOAD_INDEX_X, OP_INCREMENT_INDEX_X,
               OP_DECREMENT_INDEX_X, OP_COPY_STACK_POINTER_TO_X:
                  reg_x <= res;
               OP_LOAD_INDEX_Y, OP_INCREMENT_INDEX_Y,
               OP_DECREMENT_INDEX_Y:
                  reg_y <= res;
               default: ;
            endcase
         end
         if (take && !refuse) begin
            if (op == OP_COPY_X_TO_STACK_POINTER) begin
               reg_sp <= reg_x;
            end
            if (op == OP_CLEAR_IRQ_MASK) begin
               irq_mask <= 1'b0;
            end
            if (op == OP_SET_IRQ_MASK) begin
               irq_mask <= 1'b1;
            end
            // taken only when nonzero, else fall through
            if (op == OP_BRANCH_IF_NONZERO && !flag_zero) begin
               pc <= op_addr;
            end else begin
               pc <= op_next_pc;
            end
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_load_no_write;
      @(posedge clk) disable iff (rst)
      (take && is_load && !op_immediate) |-> ##1 !mem_wr [*3];
   endproperty
   a_load_no_write: assert property (p_load_no_write)
      else $error("write strobe during a load");

   property p_acc_hold;
      @(posedge clk) disable iff (rst)
      (idle && !op_valid) |=> $stable(reg_acc);
   endproperty
   a_acc_hold: assert property (p_acc_hold)
      else $error("accumulator changed with no operation");

   property p_imm_load;
      @(posedge clk) disable iff (rst)
      (take && op == OP_LOAD_ACCUMULATOR && op_immediate)
         |=> reg_acc == $past(op_operand) && !mem_rd;
   endproperty
   a_imm_load: assert property (p_imm_load)
      else $error("immediate load did not place operand");

   property p_load_x_mem;
      @(posedge clk) disable iff (rst)
      (take && op == OP_LOAD_INDEX_X && !op_immediate)
         |=> mem_rd ##2 reg_x == $past(mem_rdata);
   endproperty
   a_load_x_mem: assert property (p_load_x_mem)
      else $error("memory load of X wrong");

   property p_store;
      @(posedge clk) disable iff (rst)
      (do_store && op == OP_STORE_ACCUMULATOR)
         |=> mem_wr && mem_wdata == $past(reg_acc) && $stable(reg_acc);
   endproperty
   a_store: assert property (p_store)
      else $error("store wrote wrong byte or changed source");

   property p_no_imm_store;
      @(posedge clk) disable iff (rst)
      refuse |=> !mem_wr && idle;
   endproperty
   a_no_imm_store: assert property (p_no_imm_store)
      else $error("immediate store was executed");

   sequence s_rmw_read;
      state == ST_WAIT && cur_rmw && cur_up;
   endsequence
   property p_inc_mem;
      @(posedge clk) disable iff (rst)
      s_rmw_read |=> mem_wr
         && mem_wdata == 8'($past(mem_rdata) + 8'h01)
         && $stable(mem_addr);
   endproperty
   a_inc_mem: assert property (p_inc_mem)
      else $error("increment memory wrote wrong value");

   property p_inx_wrap;
      @(posedge clk) disable iff (rst)
      (take && op == OP_INCREMENT_INDEX_X && reg_x == 8'hFF)
         |=> reg_x == 8'h00 && flag_zero;
   endproperty
   a_inx_wrap: assert property (p_inx_wrap)
      else $error("X did not wrap to zero");

   property p_dey;
      @(posedge clk) disable iff (rst)
      (take && op == OP_DECREMENT_INDEX_Y)
         |=> reg_y == 8'($past(reg_y) - 8'h01);
   endproperty
   a_dey: assert property (p_dey)
      else $error("Y decrement wrong");

   property p_txa;
      @(posedge clk) disable iff (rst)
      (take && op == OP_COPY_X_TO_ACCUMULATOR)
         |=> reg_acc == $past(reg_x) && $stable(reg_x);
   endproperty
   a_txa: assert property (p_txa)
      else $error("copy X to accumulator wrong");

   property p_bne_fall;
      @(posedge clk) disable iff (rst)
      (take && op == OP_BRANCH_IF_NONZERO && flag_zero)
         |=> pc == $past(op_next_pc);
   endproperty
   a_bne_fall: assert property (p_bne_fall)
      else $error("branch taken on zero");

   property p_txs;
      @(posedge clk) disable iff (rst)
      (take && op == OP_COPY_X_TO_STACK_POINTER)
         |=> reg_sp == $past(reg_x) && $stable(flag_zero);
   endproperty
   a_txs: assert property (p_txs)
      else $error("X to stack pointer wrong");

   property p_sei;
      @(posedge clk) disable iff (rst)
      (take && op == OP_SET_IRQ_MASK) |=> irq_mask;
   endproperty
   a_sei: assert property (p_sei)
      else $error("interrupt mask not set");

endmodule

//--- hw/lsc_pkg.sv
// Package for the load, store and counter execution block.
// Assumes a single clock, one instruction presented at a time.
package lsc_pkg;

   // ****************************************************************
   // Operation codes presented on the instruction port
   // ****************************************************************
   typedef enum logic [4:0] {
      OP_NOP                      = 5'h00,
      OP_LOAD_ACCUMULATOR         = 5'h01,
      OP_LOAD_INDEX_X             = 5'h02,
      OP_LOAD_INDEX_Y             = 5'h03,
      OP_STORE_ACCUMULATOR        = 5'h04,
      OP_STORE_INDEX_X            = 5'h05,
      OP_STORE_INDEX_Y            = 5'h06,
      OP_INCREMENT_MEMORY         = 5'h07,
      OP_DECREMENT_MEMORY         = 5'h08,
      OP_INCREMENT_INDEX_X        = 5'h09,
      OP_INCREMENT_INDEX_Y        = 5'h0A,
      OP_DECREMENT_INDEX_X        = 5'h0B,
      OP_DECREMENT_INDEX_Y        = 5'h0C,
      OP_COPY_X_TO_ACCUMULATOR    = 5'h0D,
      OP_COPY_STACK_POINTER_TO_X  = 5'h0E,
      OP_COPY_X_TO_STACK_POINTER  = 5'h0F,
      OP_BRANCH_IF_NONZERO        = 5'h10,
      OP_CLEAR_IRQ_MASK           = 5'h11,
      OP_SET_IRQ_MASK             = 5'h12
   } lsc_op_t;

   // ****************************************************************
   // Execution states
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_READ  = 5'b00010,
      ST_WAIT  = 5'b00100,
      ST_WRITE = 5'b01000,
      ST_DONE  = 5'b10000
   } lsc_state_t;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0]  RST_ACC    = 8'h00;
   localparam logic [7:0]  RST_X      = 8'h00;
   localparam logic [7:0]  RST_Y      = 8'h00;
   localparam logic [7:0]  RST_SP     = 8'hFF;
   localparam logic        RST_IRQ_MASK = 1'b1;
   localparam logic [15:0] RST_PC     = 16'h0000;
   // Cycles from read strobe to data sampled (synchronous memory)
   localparam int unsigned MEM_READ_LAT = 1;

endpackage

//--- sim/lsc_mem_model.sv
// Byte-wide memory model on the block's memory bus.
// Assumes one clock; a read strobe is answered at the next edge.
`timescale 1ns/1ps
module lsc_mem_model (
   // Clock
   input  wire logic        clk,
   // Memory bus
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   // ****************************************************************
   // Storage and read port
   // ****************************************************************
   logic [7:0] mem [0:65535];

   initial mem_rdata = 8'h00;

   // Read data lasts one cycle, then flips so a late sample is caught
   always @(posedge clk) begin
      if (mem_wr === 1'b1) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (mem_rd === 1'b1) begin
         mem_rdata <= mem[mem_addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

//--- sim/tb.sv
// Self-checking bench for the load, store and counter block.
// Assumes the op codes and latencies of the package and hand-over.
`timescale 1ns/1ps
module tb;
   import lsc_pkg::*;
   logic        clk          = 1'b0;
   logic        rst          = 1'b1;
   logic        op_valid     = 1'b0;
   logic [4:0]  op_code      = 5'h00;
   logic        op_immediate = 1'b0;
   logic [7:0]  op_operand   = 8'h00;
   logic [15:0] op_addr      = 16'h0000;
   logic [15:0] op_next_pc   = 16'h0000;
   logic [15:0] npc          = 16'h0000;
   logic [7:0]  mem_rdata, mem_wdata, reg_acc, reg_x, reg_y, reg_sp;
   logic [15:0] mem_addr, pc;
   logic        op_ready, op_done, op_refused, mem_rd, mem_wr;
   logic        flag_zero, flag_negative, irq_mask;
   int          error_cnt    = 0;
   int          check_count  = 0;
   int          wr_cnt       = 0;

   lsc_exec i_dut (.clk, .rst, .op_valid, .op_code, .op_immediate,
      .op_operand, .op_addr, .op_next_pc, .op_ready, .op_done,
      .op_refused, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
      .reg_acc, .reg_x, .reg_y, .reg_sp, .flag_zero, .flag_negative,
      .irq_mask, .pc);

   lsc_mem_model i_mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
      .mem_rdata);

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      if (mem_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   function automatic logic [7:0] nz();
      return {6'h00, flag_negative, flag_zero};
   endfunction

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                       input string m);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic offer(input lsc_op_t c, input logic im,
                        input logic [7:0] d, input logic [15:0] a);
      @(posedge clk);
      op_valid     <= 1'b1;
      op_code      <= c;
      op_immediate <= im;
      op_operand   <= d;
      op_addr      <= a;
      op_next_pc   <= npc;
   endtask

   // Offer, hand over at the taking edge, then time the done pulse
   task automatic run_op(input lsc_op_t c, input logic im,
      input logic [7:0] d, input logic [15:0] a, input logic [7:0] lat);
      logic [7:0] n;
      n = 8'd0;
      offer(c, im, d, a);
      @(posedge clk);
      op_valid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (op_done !== 1'b1 && n < 8'd12);
      chk8(n, lat, "done latency");
      if (n == 8'd12) end_of_test();
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk8(reg_acc, RST_ACC, "acc reset");
      chk8(reg_sp, RST_SP, "sp reset");
      chk8({7'h00, irq_mask}, {7'h00, RST_IRQ_MASK}, "mask reset");
      chk8(pc[7:0], RST_PC[7:0], "pc reset");
      chk8(pc[15:8], RST_PC[15:8], "pc reset hi");
      chk8(reg_x, RST_X, "x reset");
      chk8(reg_y, RST_Y, "y reset");
      chk8({7'h00, op_ready}, 8'h01, "ready after reset");
      $display("test reset done");
   endtask

   task automatic t_load();
      int k;
      i_mem.mem[16'h2000] = 8'h5A;
      i_mem.mem[16'hFFFF] = 8'h80;
      i_mem.mem[16'h0000] = 8'h00;
      run_op(OP_LOAD_ACCUMULATOR, 1'b1, 8'h80, 16'h2000, 8'd1);
      chk8(reg_acc, 8'h80, "imm load acc");
      chk8(nz(), 8'h02, "flags");
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'h00, 16'h2000, 8'd1);
      chk8(reg_x, 8'h00, "imm load x");
      chk8(reg_acc, 8'h80, "acc held");
      chk8(nz(), 8'h01, "flags");
      k = wr_cnt;
      run_op(OP_LOAD_ACCUMULATOR, 1'b0, 8'hC3, 16'h2000, 8'd4);
      chk8(reg_acc, 8'h5A, "mem load acc");
      chk8(i_mem.mem[16'h2000], 8'h5A, "source kept");
      chk8(8'(wr_cnt - k), 8'h00, "no write on load");
      run_op(OP_LOAD_INDEX_X, 1'b0, 8'hC3, 16'hFFFF, 8'd4);
      chk8(reg_x, 8'h80, "mem load x");
      run_op(OP_LOAD_INDEX_Y, 1'b0, 8'hC3, 16'h0000, 8'd4);
      chk8(reg_y, 8'h00, "mem load y");
      chk8(nz(), 8'h01, "flags");
      $display("test load done");
   endtask

   task automatic t_store();
      int k;
      run_op(OP_STORE_ACCUMULATOR, 1'b0, 8'h00, 16'hFC3E, 8'd3);
      chk8(i_mem.mem[16'hFC3E], 8'h5A, "store acc");
      chk8(reg_acc, 8'h5A, "acc kept");
      run_op(OP_STORE_INDEX_X, 1'b0, 8'h00, 16'h0300, 8'd3);
      chk8(i_mem.mem[16'h0300], 8'h80, "store x");
      chk8(nz(), 8'h01, "flags kept");
      run_op(OP_STORE_INDEX_Y, 1'b0, 8'h00, 16'h0301, 8'd3);
      chk8(i_mem.mem[16'h0301], 8'h00, "store y");
      chk8(reg_y, 8'h00, "y kept");
      i_mem.mem[16'h0302] = 8'hEE;
      for (int i = 0; i < 3; i++) begin
         k = wr_cnt;
         offer(lsc_op_t'(OP_STORE_ACCUMULATOR + i), 1'b1, 8'h11, 16'h0302);
         @(negedge clk);
         chk8({7'h00, op_refused}, 8'h01, "refused");
         @(posedge clk);
         op_valid <= 1'b0;
         repeat (6) @(negedge clk);
         chk8(8'(wr_cnt - k), 8'h00, "no write");
      end
      chk8(i_mem.mem[16'h0302], 8'hEE, "memory kept");
      chk8(reg_acc, 8'h5A, "acc kept");
      $display("test store done");
   endtask

   task automatic t_count();
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'hFF, 16'h0000, 8'd1);
      run_op(OP_INCREMENT_INDEX_X, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_x, 8'h00, "x wraps up");
      chk8(nz(), 8'h01, "flags");
      run_op(OP_DECREMENT_INDEX_X, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_x, 8'hFF, "x wraps down");
      run_op(OP_LOAD_INDEX_Y, 1'b1, 8'hFF, 16'h0000, 8'd1);
      run_op(OP_INCREMENT_INDEX_Y, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_y, 8'h00, "y wraps up");
      run_op(OP_DECREMENT_INDEX_Y, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_y, 8'hFF, "y wraps down");
      chk8(nz(), 8'h02, "flags");
      i_mem.mem[16'hFC3E] = 8'hFF;
      i_mem.mem[16'hFC3F] = 8'h07;
      run_op(OP_INCREMENT_MEMORY, 1'b0, 8'h00, 16'hFC3E, 8'd5);
      chk8(i_mem.mem[16'hFC3E], 8'h00, "mem wraps up");
      chk8(i_mem.mem[16'hFC3F], 8'h07, "no carry");
      chk8(mem_addr[15:8], 8'hFC, "address hi");
      chk8(mem_addr[7:0], 8'h3E, "address lo");
      chk8(nz(), 8'h01, "flags");
      run_op(OP_DECREMENT_MEMORY, 1'b0, 8'h00, 16'hFC3E, 8'd5);
      chk8(i_mem.mem[16'hFC3E], 8'hFF, "mem wraps down");
      $display("test count done");
   endtask

   task automatic t_xfer();
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'h3C, 16'h0000, 8'd1);
      run_op(OP_COPY_X_TO_ACCUMULATOR, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_acc, 8'h3C, "x to acc");
      chk8(reg_x, 8'h3C, "x kept");
      run_op(OP_LOAD_INDEX_Y, 1'b1, 8'h00, 16'h0000, 8'd1);
      run_op(OP_COPY_X_TO_STACK_POINTER, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_sp, 8'h3C, "x to sp");
      chk8(nz(), 8'h01, "flags kept");
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'h80, 16'h0000, 8'd1);
      run_op(OP_COPY_STACK_POINTER_TO_X, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8(reg_x, 8'h3C, "sp to x");
      chk8(reg_sp, 8'h3C, "sp kept");
      chk8(nz(), 8'h00, "flags");
      run_op(OP_CLEAR_IRQ_MASK, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8({7'h00, irq_mask}, 8'h00, "mask clear");
      run_op(OP_SET_IRQ_MASK, 1'b0, 8'h00, 16'h0000, 8'd1);
      chk8({7'h00, irq_mask}, 8'h01, "mask set");
      $display("test transfer done");
   endtask

   task automatic t_branch();
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'h00, 16'h0000, 8'd1);
      npc = 16'h1234;
      run_op(OP_BRANCH_IF_NONZERO, 1'b0, 8'h00, 16'h4000, 8'd1);
      chk8(pc[15:8], 8'h12, "fall through hi");
      chk8(pc[7:0], 8'h34, "fall through lo");
      run_op(OP_LOAD_INDEX_X, 1'b1, 8'h01, 16'h0000, 8'd1);
      npc = 16'h1240;
      run_op(OP_BRANCH_IF_NONZERO, 1'b0, 8'h00, 16'h4000, 8'd1);
      chk8(pc[15:8], 8'h40, "taken hi");
      chk8(pc[7:0], 8'h00, "taken lo");
      $display("test branch done");
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_reset();
      t_load();
      t_store();
      t_count();
      t_xfer();
      t_branch();
      end_of_test();
   end
endmodule
